// file: verilog/smt_consts.vh
// Constants for the static address and reserved multicast table access block.
// Assumes byte addresses on a 16-bit register port and 32-bit data words.
`ifndef SMT_CONSTS_VH
`define SMT_CONSTS_VH

// Register byte addresses
`define SMT_OFS_CTRL 16'h041c
`define SMT_OFS_WORD1 16'h0420
`define SMT_OFS_WORD2 16'h0424
`define SMT_OFS_WORD3 16'h0428
`define SMT_OFS_WORD4 16'h042c

// Control register fields
`define SMT_CTRL_IDX_HI 5
`define SMT_CTRL_IDX_LO 0
`define SMT_CTRL_GO 7
`define SMT_CTRL_SEL 8
`define SMT_CTRL_ACT 9
`define SMT_CTRL_MASK 32'h000003bf

// Table select and action codes
`define SMT_SEL_STATIC 1'h0
`define SMT_SEL_MCAST 1'h1
`define SMT_ACT_WRITE 1'h0
`define SMT_ACT_READ 1'h1

// Writable bits of each entry word; all others read as zero
`define SMT_W1_MASK 32'hfc000007
`define SMT_W2_MASK 32'hc000007f
`define SMT_W3_MASK 32'h007fffff
`define SMT_W4_MASK 32'hffffffff

// Entry word 1 fields
`define SMT_W1_VALID 31
`define SMT_W1_SRC_DROP 30
`define SMT_W1_DST_DROP 29
`define SMT_W1_PRIO_HI 28
`define SMT_W1_PRIO_LO 26
`define SMT_W1_SPAN_HI 2
`define SMT_W1_SPAN_LO 0

// Entry word 2 fields
`define SMT_W2_OVERRIDE 31
`define SMT_W2_GRP_MATCH 30
`define SMT_W2_PORTS_HI 6
`define SMT_W2_PORTS_LO 0

// Entry word 3 fields
`define SMT_W3_FGID_HI 22
`define SMT_W3_FGID_LO 16
`define SMT_W3_MACH_HI 15
`define SMT_W3_MACH_LO 0

// Reserved multicast table geometry
`define SMT_MCAST_ADDRS 7'h30
`define SMT_RESET_WORD 32'h00000000

`endif

// file: verilog/smt_table_access.v
// Static address table (16 entries) and reserved multicast table (48 addresses,
// 8 shared port masks) with indirect access through a control word and four
// entry data words. Assumes a simple synchronous register port: one write or
// read strobe per cycle, address in bytes, read data returned one cycle later.
//
// Functional notes
// - Table select 0 picks static table
// - Action 1 requests indexed entry read
// - Action 0 writes entry from data words
// - Writing go_done 1 launches operation
// - Device clears go_done when operation completes
// - Static read fills all four data words
// - Word1 bit31 valid flag, resets zero
// - Word1 bit30 source match drop
// - Word1 bit29 destination match drop
// - Word1 priority 28:26, spanning group 2:0
// - Word2 bit31 overrides port state
// - Word2 bit30 enables multicast group match
// - Word2 bits 6:0 egress port mask
// - Word3 group id, MAC high; word4 MAC low
// - Multicast table: 48 addresses, 6-bit index
// - Eight groups share one mask each
// - Select 1 with 6-bit index picks multicast
// - Multicast mask via word2 both directions
`timescale 1ns/1ps
`include "smt_consts.vh"

module smt_table_access #(
	parameter STATIC_ENTRIES = 16,
	parameter MCAST_GROUPS = 8
) (
	input wire CORE_CLK,
	input wire RST_N,
	input wire [15:0] REG_ADDR,
	input wire REG_WR,
	input wire [31:0] REG_WDATA,
	input wire REG_RD,
	output reg [31:0] REG_RDATA,
	output reg REG_RVALID,
	output reg BUSY
);

	localparam ST_IDLE = 1'b0;
	localparam ST_EXEC = 1'b1;

	reg state_r;
	reg [5:0] idx_r;
	reg sel_r;
	reg act_r;
	reg [31:0] word1_r;
	reg [31:0] word2_r;
	reg [31:0] word3_r;
	reg [31:0] word4_r;
	reg [31:0] st_w1 [0:STATIC_ENTRIES-1];
	reg [31:0] st_w2 [0:STATIC_ENTRIES-1];
	reg [31:0] st_w3 [0:STATIC_ENTRIES-1];
	reg [31:0] st_w4 [0:STATIC_ENTRIES-1];
	reg [6:0] mc_mask [0:MCAST_GROUPS-1];
	reg [31:0] ctrl_view;
	reg [31:0] rd_nxt;
	integer i;

	integer j;
	integer k;
	reg state_nxt;
	reg busy_nxt;
	reg [31:0] word1_nxt;
	reg [31:0] word2_nxt;
	reg [31:0] word3_nxt;
	reg [31:0] word4_nxt;

	wire [3:0] st_idx = idx_r[3:0];
	wire mc_in_range = ({1'b0, idx_r} < `SMT_MCAST_ADDRS) ? 1'b1 : 1'b0;
	wire [2:0] mc_grp;

	// Fixed address-to-group map of the reserved multicast addresses
	// Indices past the table land in the last group; access to them is blocked
	function [2:0] smt_group;
		input [5:0] a;
		begin
			case (a)
				6'h00: smt_group = 3'h0;
				6'h01: smt_group = 3'h1;
				6'h02: smt_group = 3'h2;
				6'h03: smt_group = 3'h3;
				6'h04: smt_group = 3'h4;
				6'h05: smt_group = 3'h4;
				6'h06: smt_group = 3'h4;
				6'h07: smt_group = 3'h4;
				6'h08: smt_group = 3'h4;
				6'h09: smt_group = 3'h4;
				6'h0a: smt_group = 3'h4;
				6'h0b: smt_group = 3'h4;
				6'h0c: smt_group = 3'h4;
				6'h0d: smt_group = 3'h4;
				6'h0e: smt_group = 3'h4;
				6'h0f: smt_group = 3'h4;
				6'h10: smt_group = 3'h5;
				6'h11: smt_group = 3'h7;
				6'h12: smt_group = 3'h7;
				6'h13: smt_group = 3'h7;
				6'h14: smt_group = 3'h7;
				6'h15: smt_group = 3'h7;
				6'h16: smt_group = 3'h7;
				6'h17: smt_group = 3'h7;
				6'h18: smt_group = 3'h7;
				6'h19: smt_group = 3'h7;
				6'h1a: smt_group = 3'h7;
				6'h1b: smt_group = 3'h7;
				6'h1c: smt_group = 3'h7;
				6'h1d: smt_group = 3'h7;
				6'h1e: smt_group = 3'h7;
				6'h1f: smt_group = 3'h7;
				6'h20: smt_group = 3'h6;
				6'h21: smt_group = 3'h6;
				6'h22: smt_group = 3'h7;
				6'h23: smt_group = 3'h7;
				6'h24: smt_group = 3'h7;
				6'h25: smt_group = 3'h7;
				6'h26: smt_group = 3'h7;
				6'h27: smt_group = 3'h7;
				6'h28: smt_group = 3'h7;
				6'h29: smt_group = 3'h7;
				6'h2a: smt_group = 3'h7;
				6'h2b: smt_group = 3'h7;
				6'h2c: smt_group = 3'h7;
				6'h2d: smt_group = 3'h7;
				6'h2e: smt_group = 3'h7;
				6'h2f: smt_group = 3'h7;
				6'h30: smt_group = 3'h7;
				6'h31: smt_group = 3'h7;
				6'h32: smt_group = 3'h7;
				6'h33: smt_group = 3'h7;
				6'h34: smt_group = 3'h7;
				6'h35: smt_group = 3'h7;
				6'h36: smt_group = 3'h7;
				6'h37: smt_group = 3'h7;
				6'h38: smt_group = 3'h7;
				6'h39: smt_group = 3'h7;
				6'h3a: smt_group = 3'h7;
				6'h3b: smt_group = 3'h7;
				6'h3c: smt_group = 3'h7;
				6'h3d: smt_group = 3'h7;
				6'h3e: smt_group = 3'h7;
				6'h3f: smt_group = 3'h7;
				default: smt_group = 3'h7;
			endcase
		end
	endfunction

	assign mc_grp = smt_group(idx_r);

	wire ctrl_wr = REG_WR && (REG_ADDR == `SMT_OFS_CTRL);
	wire launch = ctrl_wr && (state_r == ST_IDLE) && REG_WDATA[`SMT_CTRL_GO];
	wire in_exec = (state_r == ST_EXEC) ? 1'b1 : 1'b0;
	wire sel_static = (sel_r == `SMT_SEL_STATIC) ? 1'b1 : 1'b0;
	wire act_read = (act_r == `SMT_ACT_READ) ? 1'b1 : 1'b0;
	wire exec_st_rd = in_exec && sel_static && act_read;
	wire exec_st_wr = in_exec && sel_static && !act_read;
	wire exec_mc_rd = in_exec && !sel_static && mc_in_range && act_read;
	wire exec_mc_wr = in_exec && !sel_static && mc_in_range && !act_read;
	wire wr_w1 = REG_WR && (REG_ADDR == `SMT_OFS_WORD1);
	wire wr_w2 = REG_WR && (REG_ADDR == `SMT_OFS_WORD2);
	wire wr_w3 = REG_WR && (REG_ADDR == `SMT_OFS_WORD3);
	wire wr_w4 = REG_WR && (REG_ADDR == `SMT_OFS_WORD4);

	// Operation sequencer: one execute cycle per launch
	always @* begin
		state_nxt = state_r;
		busy_nxt = BUSY;
		case (state_r)
			ST_IDLE: begin
				if (launch) begin
					state_nxt = ST_EXEC;
					busy_nxt = 1'b1;
				end
			end
			ST_EXEC: begin
				state_nxt = ST_IDLE;
				busy_nxt = 1'b0;
			end
			default: begin
				state_nxt = ST_IDLE;
				busy_nxt = 1'b0;
			end
		endcase
	end

	always @(posedge CORE_CLK) begin
		if (!RST_N) begin
			state_r <= ST_IDLE;
			BUSY <= 1'b0;
		end else begin
			state_r <= state_nxt;
			BUSY <= busy_nxt;
		end
	end

	// Control fields only change while idle
	always @(posedge CORE_CLK) begin
		if (!RST_N) begin
			idx_r <= 6'h00;
			sel_r <= `SMT_SEL_STATIC;
			act_r <= `SMT_ACT_WRITE;
		end else if (ctrl_wr && (state_r == ST_IDLE)) begin
			idx_r <= REG_WDATA[`SMT_CTRL_IDX_HI:`SMT_CTRL_IDX_LO];
			sel_r <= REG_WDATA[`SMT_CTRL_SEL];
			act_r <= REG_WDATA[`SMT_CTRL_ACT];
		end
	end

	// Entry data words: reserved bits never stored; a table read wins over a host write
	always @* begin
		word1_nxt = word1_r;
		if (wr_w1) begin
			word1_nxt = REG_WDATA & `SMT_W1_MASK;
		end
		if (exec_st_rd) begin
			word1_nxt = st_w1[st_idx];
		end
	end

	always @* begin
		word2_nxt = word2_r;
		if (wr_w2) begin
			word2_nxt = REG_WDATA & `SMT_W2_MASK;
		end
		if (exec_st_rd) begin
			word2_nxt = st_w2[st_idx];
		end
		if (exec_mc_rd) begin
			word2_nxt = {25'h0, mc_mask[mc_grp]};
		end
	end

	always @* begin
		word3_nxt = word3_r;
		if (wr_w3) begin
			word3_nxt = REG_WDATA & `SMT_W3_MASK;
		end
		if (exec_st_rd) begin
			word3_nxt = st_w3[st_idx];
		end
	end

	always @* begin
		word4_nxt = word4_r;
		if (wr_w4) begin
			word4_nxt = REG_WDATA & `SMT_W4_MASK;
		end
		if (exec_st_rd) begin
			word4_nxt = st_w4[st_idx];
		end
	end

	always @(posedge CORE_CLK) begin
		if (!RST_N) begin
			word1_r <= `SMT_RESET_WORD;
			word2_r <= `SMT_RESET_WORD;
			word3_r <= `SMT_RESET_WORD;
			word4_r <= `SMT_RESET_WORD;
		end else begin
			word1_r <= word1_nxt;
			word2_r <= word2_nxt;
			word3_r <= word3_nxt;
			word4_r <= word4_nxt;
		end
	end

	// Static table store, words 1 and 2; only the indexed entry moves
	always @(posedge CORE_CLK) begin
		if (!RST_N) begin
			for (i = 0; i < STATIC_ENTRIES; i = i + 1) begin
				st_w1[i] <= `SMT_RESET_WORD;
				st_w2[i] <= `SMT_RESET_WORD;
			end
		end else if (exec_st_wr) begin
			st_w1[st_idx] <= word1_r;
			st_w2[st_idx] <= word2_r;
		end
	end

	// Static table store, words 3 and 4
	always @(posedge CORE_CLK) begin
		if (!RST_N) begin
			for (k = 0; k < STATIC_ENTRIES; k = k + 1) begin
				st_w3[k] <= `SMT_RESET_WORD;
				st_w4[k] <= `SMT_RESET_WORD;
			end
		end else if (exec_st_wr) begin
			st_w3[st_idx] <= word3_r;
			st_w4[st_idx] <= word4_r;
		end
	end

	// One shared mask per group, so a write reaches every address in it
	always @(posedge CORE_CLK) begin
		if (!RST_N) begin
			for (j = 0; j < MCAST_GROUPS; j = j + 1) begin
				mc_mask[j] <= 7'h00;
			end
		end else if (exec_mc_wr) begin
			mc_mask[mc_grp] <= word2_r[`SMT_W2_PORTS_HI:`SMT_W2_PORTS_LO];
		end
	end

	// Read-back mux; unmapped addresses return zero
	always @* begin
		ctrl_view = 32'h00000000;
		ctrl_view[`SMT_CTRL_IDX_HI:`SMT_CTRL_IDX_LO] = idx_r;
		ctrl_view[`SMT_CTRL_GO] = BUSY;
		ctrl_view[`SMT_CTRL_SEL] = sel_r;
		ctrl_view[`SMT_CTRL_ACT] = act_r;
		case (REG_ADDR)
			`SMT_OFS_CTRL: begin
				rd_nxt = ctrl_view;
			end
			`SMT_OFS_WORD1: begin
				rd_nxt = word1_r;
			end
			`SMT_OFS_WORD2: begin
				rd_nxt = word2_r;
			end
			`SMT_OFS_WORD3: begin
				rd_nxt = word3_r;
			end
			`SMT_OFS_WORD4: begin
				rd_nxt = word4_r;
			end
			default: begin
				rd_nxt = 32'h00000000;
			end
		endcase
	end

	always @(posedge CORE_CLK) begin
		if (!RST_N) begin
			REG_RDATA <= 32'h00000000;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_RD;
			if (REG_RD) begin
				REG_RDATA <= rd_nxt;
			end
		end
	end

endmodule

// file: bench/smt_table_access_asserts.sv
// Port checker for the table access block.
// Bound onto smt_table_access; one clock, synchronous reset.
`timescale 1ns/1ps
`include "smt_consts.vh"
module smt_chk (
	input wire CORE_CLK,
	input wire RST_N,
	input wire [15:0] REG_ADDR,
	input wire REG_WR,
	input wire [31:0] REG_WDATA,
	input wire REG_RD,
	input wire [31:0] REG_RDATA,
	input wire REG_RVALID,
	input wire BUSY
);
	wire go_w = REG_WR && REG_ADDR == `SMT_OFS_CTRL && REG_WDATA[`SMT_CTRL_GO];
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	property p_go; go_w && !BUSY |=> BUSY ##1 !BUSY; endproperty
	a_go: assert property (p_go) else $error("op length");
	property p_ign; go_w && BUSY |=> !BUSY; endproperty
	a_ign: assert property (p_ign) else $error("relaunch");
	property p_rise; $rose(BUSY) |-> $past(go_w); endproperty
	a_rise: assert property (p_rise) else $error("busy cause");
	property p_w1; REG_RD && REG_ADDR == 16'h0420 |=> !(REG_RDATA & ~`SMT_W1_MASK); endproperty
	a_w1: assert property (p_w1) else $error("word1 reserved");
	property p_w2; REG_RD && REG_ADDR == 16'h0424 |=> !(REG_RDATA & ~`SMT_W2_MASK); endproperty
	a_w2: assert property (p_w2) else $error("word2 reserved");
	property p_w3; REG_RD && REG_ADDR == 16'h0428 |=> !(REG_RDATA & ~`SMT_W3_MASK); endproperty
	a_w3: assert property (p_w3) else $error("word3 reserved");
	property p_gord; REG_RD && REG_ADDR == `SMT_OFS_CTRL && BUSY |=> REG_RDATA[7]; endproperty
	a_gord: assert property (p_gord) else $error("go readback");
	property p_hold; !REG_RVALID |-> $stable(REG_RDATA); endproperty
	a_hold: assert property (p_hold) else $error("rdata moved");
endmodule
bind smt_table_access smt_chk u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
	.REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.REG_RVALID(REG_RVALID), .BUSY(BUSY));

// file: bench/smt_table_access_tb.sv
// Bench for the table access block.
// Drives the register port itself; checker bound beside it.
`timescale 1ns/1ps
`include "smt_consts.vh"
module smt_table_access_tb;
	reg CORE_CLK = 1'b0;
	reg RST_N = 1'b0;
	reg [15:0] REG_ADDR = 16'h0000;
	reg REG_WR = 1'b0;
	reg [31:0] REG_WDATA = 32'h00000000;
	reg REG_RD = 1'b0;
	wire [31:0] REG_RDATA;
	wire REG_RVALID;
	wire BUSY;
	integer n_mismatch = 0;
	integer samples_checked = 0;
	reg [15:0] a;
	always #2 CORE_CLK = ~CORE_CLK;
	smt_table_access dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
		.REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.REG_RVALID(REG_RVALID), .BUSY(BUSY));
	task chk(input [31:0] got, input [31:0] exp);
		begin
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
		end
	endtask
	task wr(input [15:0] ad, input [31:0] d);
		begin
		@(posedge CORE_CLK);
		REG_ADDR <= ad;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CORE_CLK);
		REG_WR <= 1'b0;
		end
	endtask
	task rd(input [15:0] ad, input [31:0] e);
		begin
		@(posedge CORE_CLK);
		REG_ADDR <= ad;
		REG_RD <= 1'b1;
		@(posedge CORE_CLK);
		REG_RD <= 1'b0;
		#1;
		chk(REG_RVALID, 32'h1);
		chk(REG_RDATA, e);
		end
	endtask
	// Launch, one busy cycle, then go reads back clear
	task op(input sel, input act, input [5:0] idx);
		begin
		wr(16'h041c, {22'h0, act, sel, 2'b10, idx});
		#1;
		chk(BUSY, 32'h1);
		@(posedge CORE_CLK);
		#1;
		chk(BUSY, 32'h0);
		rd(16'h041c, {22'h0, act, sel, 2'b00, idx});
		end
	endtask
	task summarize;
		begin
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
		end
	endtask
	initial begin
		#20000;
		n_mismatch = n_mismatch + 1;
		summarize;
	end
	initial begin
		repeat (8) @(posedge CORE_CLK);
		RST_N <= 1'b1;
		for (a = 16'h041c; a < 16'h0434; a = a + 16'h0004)
			rd(a, 32'h0);
		$display("reset test done");
		for (a = 16'h0420; a < 16'h0430; a = a + 16'h0004)
			wr(a, 32'hffffffff);
		op(1'b0, 1'b0, 6'h0f);
		for (a = 16'h0420; a < 16'h0430; a = a + 16'h0004)
			wr(a, 32'h0);
		op(1'b0, 1'b1, 6'h0f);
		rd(16'h0420, `SMT_W1_MASK);
		rd(16'h0424, `SMT_W2_MASK);
		rd(16'h0428, `SMT_W3_MASK);
		rd(16'h042c, `SMT_W4_MASK);
		op(1'b0, 1'b1, 6'h00);
		rd(16'h0420, 32'h0);
		$display("static test done");
		wr(16'h042c, 32'h12345678);
		@(posedge CORE_CLK);
		REG_ADDR <= 16'h041c;
		REG_WDATA <= {22'h0, 2'b01, 2'b10, 6'h0f};
		REG_WR <= 1'b1;
		@(posedge CORE_CLK);
		REG_WDATA <= {22'h0, 2'b00, 2'b10, 6'h01};
		@(posedge CORE_CLK);
		REG_WR <= 1'b0;
		rd(16'h041c, {22'h0, 2'b01, 2'b00, 6'h0f});
		op(1'b0, 1'b1, 6'h01);
		rd(16'h042c, 32'h0);
		$display("busy test done");
		wr(16'h0424, 32'h00000055);
		op(1'b1, 1'b0, 6'h05);
		wr(16'h0424, `SMT_W2_MASK);
		op(1'b1, 1'b1, 6'h0f);
		rd(16'h0424, 32'h00000055);
		op(1'b1, 1'b1, 6'h10);
		rd(16'h0424, 32'h0);
		$display("multicast test done");
		summarize;
	end
endmodule
